// File: design/fwg_consts.svh
`ifndef FWG_CONSTS_SVH
`define FWG_CONSTS_SVH

// opcodes
`define FWG_OP_WREN 8'h06
`define FWG_OP_WRDI 8'h04
`define FWG_OP_VWREN 8'h50
`define FWG_OP_BLOCK_LOCK 8'h36
`define FWG_OP_BLOCK_UNLOCK 8'h39
`define FWG_OP_PP 8'h02
`define FWG_OP_PP_DUAL 8'hA2
`define FWG_OP_PP_QUAD 8'h32
`define FWG_OP_SEQ_A 8'hAF
`define FWG_OP_SEQ_B 8'hAD
`define FWG_OP_ER_4K 8'h20
`define FWG_OP_ER_32K 8'h52
`define FWG_OP_ER_64K 8'hD8
`define FWG_OP_ER_CHIP_A 8'h60
`define FWG_OP_ER_CHIP_B 8'hC7
`define FWG_OP_OTP_PROG 8'h9B
`define FWG_OP_WRSR1 8'h01
`define FWG_OP_WRSR3 8'h31
`define FWG_OP_WRSR2 8'h11
`define FWG_OP_WRSR5 8'h71

// frame layout
`define FWG_OPC_BITS 8
`define FWG_ADDR_BITS 24
`define FWG_LOCK_FRAME_BITS 32
`define FWG_BLOCK_SHIFT 12
`define FWG_ADDR_MSB 23

`endif

// File: design/fwg_pkg.sv
package fwg_pkg;
	// event carried from the link domain at chip-select rise
	typedef struct packed {
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [5:0] nbits;
		logic whole;
	} fwg_frame_t;

	typedef enum logic [2:0] {
		FWG_IDLE = 3'b001,
		FWG_EXEC = 3'b010,
		FWG_ACK = 3'b100
	} fwg_state_t;

	typedef struct packed {
		logic [2:0] sync;
		logic done_tgl;
	} fwg_xing_t;
endpackage : fwg_pkg

// File: design/fwg_spi_shift.sv
`timescale 1ns/1ps
`include "fwg_consts.svh"

// link-clock side: shifts SI and snaps the frame at chip select rise
module fwg_spi_shift
	import fwg_pkg::*;
(
	// link
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_si,
	// reset from the core side, released only while cs is high
	input wire logic i_link_rst,
	// frame out
	output logic o_frame_tgl,
	output fwg_frame_t o_frame
);
	typedef struct packed {
		logic [31:0] shreg;
		logic [7:0] opc;
		logic [23:0] addr;
		logic [5:0] cnt;
	} fwg_shift_st_t;

	fwg_shift_st_t st_ff;
	fwg_shift_st_t nxt_st;

	// ****************************************
	// shift in, msb first
	// ****************************************
	// msb first shift
	always_comb begin
		nxt_st = st_ff;
		nxt_st.shreg = {st_ff.shreg[30:0], i_si};
		if (st_ff.cnt != 6'h3F) begin
			nxt_st.cnt = st_ff.cnt + 6'h01;
		end
		// opcode is always the first byte, whatever follows it
		if (st_ff.cnt == 6'(`FWG_OPC_BITS - 1)) begin
			nxt_st.opc = {st_ff.shreg[6:0], i_si};
		end
		// address is the three bytes after it, not the tail of a long frame
		if (st_ff.cnt == 6'(`FWG_LOCK_FRAME_BITS - 1)) begin
			nxt_st.addr = {st_ff.shreg[22:0], i_si};
		end
	end

	// counter is cleared asynchronously by cs, since sck stops outside frames
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// frame capture at cs rise
	// ****************************************
	// snapshot is safe: sck is idle around cs rise
	always_ff @(posedge i_cs_n) begin
		o_frame.nbits <= st_ff.cnt;
		o_frame.whole <= (st_ff.cnt[2:0] == 3'h0) && (st_ff.cnt != 6'h00);
		o_frame.opcode <= st_ff.opc;
		o_frame.addr <= st_ff.addr;
	end

	// toggle needs a defined start, or the core never sees an edge
	always_ff @(posedge i_cs_n or posedge i_link_rst) begin
		if (i_link_rst) begin
			o_frame_tgl <= 1'b0;
		end else begin
			o_frame_tgl <= ~o_frame_tgl;
		end
	end
endmodule : fwg_spi_shift

// File: design/fwg_guard.sv
`timescale 1ns/1ps
`include "fwg_consts.svh"

// How it works
// - cs off byte boundary aborts command
// - opcode eight clocks msb first
// - 04h clears write enable latch
// - program commands refused without latch
// - erase commands refused without latch
// - otp and status writes refused too
// - 50h leaves latch unchanged
// - volatile permission covers next write only
// - 36h opcode plus 24-bit address locks
// - 39h opcode plus address unlocks
// - lock needs latch set first
// - unlock needs latch set first
// - update lock bit then clear latch
// - lock bits count only with scheme select
// - all lock bits reset to one
// - locked block refuses program and erase
// - 06h sets write enable latch
// - lock granule is 4 kB
module fwg_guard
	import fwg_pkg::*;
#(
	parameter int ADDR_BITS = 20
) (
	// core clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	// spi link
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_si,
	// protection configuration
	input wire logic i_protect_scheme_select,
	input wire logic i_range_protected,
	// query from program/erase engine
	input wire logic [23:0] i_query_addr,
	input wire logic i_query_is_chip,
	// status
	output logic o_write_enable_latch,
	output logic o_volatile_wr_enable,
	output logic o_query_protected,
	output logic o_exec_pulse,
	output logic [7:0] o_exec_opcode,
	output logic o_exec_allowed,
	output logic o_volatile_write_done,
	output logic o_lock_bit
);
	// ****************************************
	// sizes and elaboration checks
	// ****************************************
	localparam int NBLK = 1 << (ADDR_BITS - `FWG_BLOCK_SHIFT);
	localparam int BLK_BITS = ADDR_BITS - `FWG_BLOCK_SHIFT;

	initial begin
		if (ADDR_BITS <= `FWG_BLOCK_SHIFT || ADDR_BITS > `FWG_ADDR_BITS) begin
			$error("fwg_guard: ADDR_BITS out of range");
		end
		// a lock frame is exactly one opcode and one address
		if (`FWG_LOCK_FRAME_BITS != `FWG_OPC_BITS + `FWG_ADDR_BITS) begin
			$error("fwg_guard: lock frame layout inconsistent");
		end
		// the link bit counter saturates at 63
		if (`FWG_LOCK_FRAME_BITS >= 63) begin
			$error("fwg_guard: lock frame longer than the bit counter");
		end
		if (`FWG_ADDR_MSB + 1 != `FWG_ADDR_BITS) begin
			$error("fwg_guard: address msb does not match address width");
		end
	end

	// ****************************************
	// core state
	// ****************************************
	typedef struct packed {
		fwg_state_t state;
		logic [2:0] sync;
		logic seen_tgl;
		fwg_frame_t frame;
		logic write_enable_latch;
		logic vwe;
		logic [NBLK-1:0] lock;
		logic exec_pulse;
		logic [7:0] exec_opcode;
		logic exec_allowed;
		logic vwrite_done;
		logic query_prot;
		logic lock_rd;
	} fwg_core_st_t;

	fwg_core_st_t st_ff;
	fwg_core_st_t nxt_st;

	logic frame_tgl;
	fwg_frame_t frame_link;

	// ****************************************
	// link domain
	// ****************************************
	fwg_spi_shift u_shift (
		.i_sck(i_sck),
		.i_cs_n(i_cs_n),
		.i_si(i_si),
		.i_link_rst(i_sys_rst),
		.o_frame_tgl(frame_tgl),
		.o_frame(frame_link)
	);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic needs_wel(input logic [7:0] op);
		unique case (op)
			`FWG_OP_PP, `FWG_OP_PP_DUAL, `FWG_OP_PP_QUAD,
			`FWG_OP_SEQ_A, `FWG_OP_SEQ_B: needs_wel = 1'b1;
			`FWG_OP_ER_4K, `FWG_OP_ER_32K, `FWG_OP_ER_64K,
			`FWG_OP_ER_CHIP_A, `FWG_OP_ER_CHIP_B: needs_wel = 1'b1;
			`FWG_OP_OTP_PROG, `FWG_OP_WRSR1, `FWG_OP_WRSR3,
			`FWG_OP_WRSR2, `FWG_OP_WRSR5: needs_wel = 1'b1;
			default: needs_wel = 1'b0;
		endcase
	endfunction : needs_wel

	// otp and status writes touch no array block, so no lock check
	function automatic logic is_prog_erase(input logic [7:0] op);
		unique case (op)
			`FWG_OP_PP, `FWG_OP_PP_DUAL, `FWG_OP_PP_QUAD,
			`FWG_OP_SEQ_A, `FWG_OP_SEQ_B: is_prog_erase = 1'b1;
			`FWG_OP_ER_4K, `FWG_OP_ER_32K, `FWG_OP_ER_64K,
			`FWG_OP_ER_CHIP_A, `FWG_OP_ER_CHIP_B: is_prog_erase = 1'b1;
			default: is_prog_erase = 1'b0;
		endcase
	endfunction : is_prog_erase

	function automatic logic is_chip_erase(input logic [7:0] op);
		is_chip_erase = (op == `FWG_OP_ER_CHIP_A) || (op == `FWG_OP_ER_CHIP_B);
	endfunction : is_chip_erase

	function automatic logic [ADDR_BITS-`FWG_BLOCK_SHIFT-1:0] blk_of(input logic [23:0] a);
		blk_of = a[ADDR_BITS-1:`FWG_BLOCK_SHIFT];
	endfunction : blk_of

	function automatic logic prot_of(input logic [NBLK-1:0] lk, input logic [23:0] a,
			input logic chip, input logic sel, input logic rng);
		if (!sel) begin
			prot_of = rng;
		end else if (chip) begin
			// chip-wide work is refused while any block stays locked
			prot_of = |lk;
		end else begin
			prot_of = lk[blk_of(a)];
		end
	endfunction : prot_of

	// ****************************************
	// lock granule decode
	// ****************************************
	// one compare per granule turns the lock update into a plain mask
	logic [NBLK-1:0] blk_hit;
	for (genvar g = 0; g < NBLK; g++) begin : g_blk
		assign blk_hit[g] = blk_of(st_ff.frame.addr) == BLK_BITS'(g);
	end

	// ****************************************
	// core next state
	// ****************************************
	always_comb begin
		logic ok;
		logic is_lock;
		logic is_unlock;
		ok = 1'b0;
		is_lock = 1'b0;
		is_unlock = 1'b0;
		nxt_st = st_ff;
		// two stages settle the toggle, the third finds its edge
		nxt_st.sync = {st_ff.sync[1:0], frame_tgl};
		nxt_st.exec_pulse = 1'b0;
		nxt_st.vwrite_done = 1'b0;
		nxt_st.query_prot = prot_of(st_ff.lock, i_query_addr, i_query_is_chip,
			i_protect_scheme_select, i_range_protected);
		nxt_st.lock_rd = st_ff.lock[blk_of(i_query_addr)];
		unique case (st_ff.state)
			FWG_IDLE: begin
				if (st_ff.sync[2] != st_ff.seen_tgl) begin
					nxt_st.seen_tgl = st_ff.sync[2];
					// frame is stable long before the toggle lands here
					nxt_st.frame = frame_link;
					nxt_st.state = FWG_EXEC;
				end
			end
			FWG_EXEC: begin
				nxt_st.state = FWG_ACK;
				is_lock = st_ff.frame.opcode == `FWG_OP_BLOCK_LOCK;
				is_unlock = st_ff.frame.opcode == `FWG_OP_BLOCK_UNLOCK;
				if (st_ff.frame.whole) begin
					if (is_lock || is_unlock) begin
						ok = st_ff.frame.nbits == 6'(`FWG_LOCK_FRAME_BITS)
							&& st_ff.write_enable_latch;
					end else if (needs_wel(st_ff.frame.opcode)) begin
						ok = st_ff.write_enable_latch && !(is_prog_erase(st_ff.frame.opcode)
							&& prot_of(st_ff.lock, st_ff.frame.addr,
								is_chip_erase(st_ff.frame.opcode),
								i_protect_scheme_select, i_range_protected));
					end else begin
						ok = st_ff.frame.nbits == 6'(`FWG_OPC_BITS);
					end
				end
				unique case (st_ff.frame.opcode)
					`FWG_OP_WREN: begin
						if (ok) nxt_st.write_enable_latch = 1'b1;
					end
					`FWG_OP_WRDI: begin
						if (ok) nxt_st.write_enable_latch = 1'b0;
					end
					`FWG_OP_VWREN: begin
						if (ok) nxt_st.vwe = 1'b1;
					end
					`FWG_OP_BLOCK_LOCK, `FWG_OP_BLOCK_UNLOCK: begin
						if (ok) begin
							if (is_lock) begin
								nxt_st.lock = st_ff.lock | blk_hit;
							end else begin
								nxt_st.lock = st_ff.lock & ~blk_hit;
							end
							nxt_st.write_enable_latch = 1'b0;
						end
					end
					`FWG_OP_WRSR1: begin
						if (ok) begin
							nxt_st.vwrite_done = st_ff.vwe;
							nxt_st.vwe = 1'b0;
						end
					end
					default: begin
					end
				endcase
				// any other executed command withdraws it
				if (ok && st_ff.frame.opcode != `FWG_OP_VWREN
						&& st_ff.frame.opcode != `FWG_OP_WRSR1) begin
					nxt_st.vwe = 1'b0;
				end
				nxt_st.exec_pulse = 1'b1;
				nxt_st.exec_opcode = st_ff.frame.opcode;
				nxt_st.exec_allowed = ok;
			end
			FWG_ACK: begin
				nxt_st.state = FWG_IDLE;
			end
		endcase
	end

	// ****************************************
	// core registers
	// ****************************************
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			st_ff <= '0;
			st_ff.state <= FWG_IDLE;
			st_ff.lock <= '1;
		end else if (i_clk_en) begin
			// a frame ending while frozen waits in the toggle; a second one flips it back and both are lost
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// status outputs
	// ****************************************
	assign o_write_enable_latch = st_ff.write_enable_latch;
	assign o_volatile_wr_enable = st_ff.vwe;
	assign o_query_protected = st_ff.query_prot;
	assign o_exec_pulse = st_ff.exec_pulse;
	assign o_exec_opcode = st_ff.exec_opcode;
	assign o_exec_allowed = st_ff.exec_allowed;
	assign o_volatile_write_done = st_ff.vwrite_done;
	assign o_lock_bit = st_ff.lock_rd;
endmodule : fwg_guard

// File: tb/fwg_guard_asserts.sv
`timescale 1ns/1ps
// ****************
// guard checker
// ****************
module fwg_guard_asserts (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// configuration
	input wire logic i_protect_scheme_select,
	input wire logic i_range_protected,
	// status
	input wire logic o_write_enable_latch,
	input wire logic o_volatile_wr_enable,
	input wire logic o_query_protected,
	input wire logic o_exec_pulse,
	input wire logic [7:0] o_exec_opcode,
	input wire logic o_exec_allowed,
	input wire logic o_volatile_write_done,
	input wire logic o_lock_bit
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	logic ok;
	assign ok = o_exec_pulse && o_exec_allowed;
	property p_keep; o_exec_pulse && !o_exec_allowed |-> $stable(o_write_enable_latch); endproperty
	a_keep: assert property (p_keep) else $error("refused frame moved latch");
	property p_wren; ok && o_exec_opcode == 8'h06 |-> o_write_enable_latch; endproperty
	a_wren: assert property (p_wren) else $error("latch not set");
	property p_wrdi; ok && o_exec_opcode == 8'h04 |-> !o_write_enable_latch; endproperty
	a_wrdi: assert property (p_wrdi) else $error("latch not cleared");
	property p_vwren;
		ok && o_exec_opcode == 8'h50 |-> $stable(o_write_enable_latch) && o_volatile_wr_enable;
	endproperty
	a_vwren: assert property (p_vwren) else $error("volatile enable wrong");
	property p_lock;
		ok && o_exec_opcode inside {8'h36, 8'h39} |-> $past(o_write_enable_latch)
			&& !o_write_enable_latch;
	endproperty
	a_lock: assert property (p_lock) else $error("lock without latch");
	property p_guard;
		ok && o_exec_opcode inside {8'h02, 8'hA2, 8'h32, 8'hAF, 8'hAD, 8'h20, 8'h52, 8'hD8,
			8'h60, 8'hC7, 8'h9B, 8'h01, 8'h31, 8'h11, 8'h71} |-> $past(o_write_enable_latch);
	endproperty
	a_guard: assert property (p_guard) else $error("guarded op ran");
	property p_once;
		o_volatile_write_done |-> o_exec_pulse && $past(o_volatile_wr_enable)
			&& !o_volatile_wr_enable;
	endproperty
	a_once: assert property (p_once) else $error("volatile permission kept");
	property p_range;
		!i_protect_scheme_select |=> o_query_protected == $past(i_range_protected);
	endproperty
	a_range: assert property (p_range) else $error("range result ignored");
	property p_rst; $fell(i_sys_rst) |-> !o_write_enable_latch ##1 o_lock_bit; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : fwg_guard_asserts

bind fwg_guard fwg_guard_asserts u_chk (.*);

// File: tb/fwg_host.sv
`timescale 1ns/1ps
// ****************
// spi host model
// ****************
module fwg_host (
	// link pins
	output logic o_sck,
	output logic o_cs_n,
	output logic o_si
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b1;
	end
	task automatic send(input logic [31:0] b, input int n);
		int i;
		#7;
		o_cs_n = 1'b0;
		for (i = n - 1; i >= 0; i--) begin
			o_si = b[i];
			#16 o_sck = 1'b1;
			#16 o_sck = 1'b0;
		end
		#16 o_cs_n = 1'b1;
		// released line shows no stale bit
		o_si = ~o_si;
	endtask : send
endmodule : fwg_host

// File: tb/test_fwg_guard.sv
`timescale 1ns/1ps
// ****************
// guard bench
// ****************
module test_fwg_guard;
	logic i_core_clk, i_sys_rst, i_sck, i_cs_n, i_si, sel, rng, chip;
	logic [23:0] qa;
	logic latch, vol, qprot, pulse, ok, vdone, lockb;
	logic [7:0] opc;
	logic vd_seen;
	logic [7:0] gop [15] = '{8'h02, 8'hA2, 8'h32, 8'hAF, 8'hAD, 8'h20, 8'h52, 8'hD8, 8'h60,
		8'hC7, 8'h9B, 8'h01, 8'h31, 8'h11, 8'h71};
	int err_total, comparisons;
	fwg_host u_host (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si));
	fwg_guard u_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
		.i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si), .i_protect_scheme_select(sel),
		.i_range_protected(rng), .i_query_addr(qa), .i_query_is_chip(chip),
		.o_write_enable_latch(latch), .o_volatile_wr_enable(vol), .o_query_protected(qprot),
		.o_exec_pulse(pulse), .o_exec_opcode(opc), .o_exec_allowed(ok),
		.o_volatile_write_done(vdone), .o_lock_bit(lockb));
	initial begin
		i_core_clk = 1'b0;
		forever #2.5 i_core_clk = ~i_core_clk;
	end
	task automatic wrap_up;
		if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// frame, then wait for its bounded answer
	task automatic fr(input logic [31:0] b, input int n, input logic exp);
		int i;
		u_host.send(b, n);
		for (i = 0; i < 40 && pulse !== 1'b1; i++) begin
			@(posedge i_core_clk);
			#1;
		end
		chk({pulse, ok}, {1'b1, exp});
		if (n >= 8) chk(opc, b[n-1 -: 8]);
		vd_seen = vdone;
		repeat (10) @(posedge i_core_clk);
	endtask : fr
	task automatic look(input logic [23:0] a, input logic exp);
		@(posedge i_core_clk);
		qa <= a;
		repeat (3) @(posedge i_core_clk);
		#1;
		chk({lockb, qprot}, {exp, exp});
	endtask : look
	initial begin
		#150us;
		err_total++;
		wrap_up;
	end
	initial begin
		{sel, rng, chip} = 3'b100;
		qa = 24'h0;
		i_sys_rst = 1'b1;
		repeat (12) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		repeat (2) @(posedge i_core_clk);
		#1;
		chk({latch, lockb}, 2'b01);
		fr(32'h03, 7, 1'b0);
		foreach (gop[k]) fr({24'h0, gop[k]}, 8, 1'b0);
		fr(32'h36012000, 32, 1'b0);
		fr(32'h06, 8, 1'b1);
		fr(32'h008, 9, 1'b0);
		fr(32'h390123, 24, 1'b0);
		chk(latch, 1'b1);
		fr(32'h39012345, 32, 1'b1);
		chk(latch, 1'b0);
		look(24'h012FFF, 1'b0);
		look(24'h013000, 1'b1);
		fr(32'h39013000, 32, 1'b0);
		fr(32'h06, 8, 1'b1);
		fr(32'h20012800, 32, 1'b1);
		fr(32'h06, 8, 1'b1);
		fr(32'h20013000, 32, 1'b0);
		chk(latch, 1'b1);
		fr(32'h60, 8, 1'b0);
		fr(32'h36012ABC, 32, 1'b1);
		look(24'h012000, 1'b1);
		fr(32'h06, 8, 1'b1);
		fr(32'h50, 8, 1'b1);
		chk({latch, vol, vd_seen}, 3'b110);
		fr(32'h0100, 16, 1'b1);
		chk({vd_seen, vol}, 2'b10);
		fr(32'h0100, 16, 1'b1);
		chk(vd_seen, 1'b0);
		fr(32'h06, 8, 1'b1);
		fr(32'h04, 8, 1'b1);
		chk(latch, 1'b0);
		@(posedge i_core_clk);
		chip <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		#1;
		chk(qprot, 1'b1);
		@(posedge i_core_clk);
		{sel, rng, chip} <= 3'b010;
		repeat (3) @(posedge i_core_clk);
		#1;
		chk(qprot, 1'b1);
		@(posedge i_core_clk);
		rng <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		#1;
		chk(qprot, 1'b0);
		wrap_up;
	end
endmodule : test_fwg_guard
